// [logic/psc_pkg.sv]
package psc_pkg;

    // ------------------------------------------------------------------
    // Register indices and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_SOFT_CAPTURE   = 8'h08;
    localparam logic [7:0] REG_HARD_CAPTURE   = 8'h09;
    localparam logic [7:0] REG_TARGET_ADDRESS = 8'h0A;

    localparam int SOFT_MODE_BIT   = 7;
    localparam int SOFT_STRAP_LSB  = 4;
    localparam int HARD_STRAP_LSB  = 2;
    localparam int ADDR_LOW_LSB    = 1;

    localparam logic [7:0] SOFT_CAPTURE_RESET   = 8'h00;
    localparam logic [7:0] HARD_CAPTURE_RESET   = 8'h00;
    localparam logic [7:0] TARGET_ADDRESS_RESET = 8'h54;

    // Edge count after reset release; the capture fires when it reaches one.
    localparam logic [1:0] CAPTURE_WAIT_RESET = 2'h3;
    localparam logic [1:0] CAPTURE_WAIT_FIRE  = 2'h1;

    // ------------------------------------------------------------------
    // Three-level strap encoding
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PSC_LVL_LOW  = 2'h0,
        PSC_LVL_MID  = 2'h1,
        PSC_LVL_HIGH = 2'h2
    } psc_level_e;

    localparam logic [1:0] ADDR_LOW_FOR_LOW  = 2'h0;
    localparam logic [1:0] ADDR_LOW_FOR_MID  = 2'h1;
    localparam logic [1:0] ADDR_LOW_FOR_HIGH = 2'h3;
    localparam logic [1:0] ADDR_LOW_HARD     = 2'h0;

    localparam logic [2:0] SOFT_CODE_HIGH_BASE = 3'h3;

endpackage : psc_pkg

// [logic/psc_pin_strap_capture.sv]
// What this block does
// - Strap pins are latched into the capture registers on the third clock edge after reset releases and held until the next reset.
// - Bit 7 of the soft capture holds the sampled mode select pin: 0 soft mode, 1 hard mode.
// - In soft mode bits 6:4 code straps 3 and 2 as 0..5 for low/low up to high/high.
// - In hard mode bits 7:2 of the hard capture hold straps 5:0 as a binary value.
// - In soft mode the hard strap field reads zero.
// - The target address sits in bits 7:1 with default 0x54 and bit 0 reserved.
// - The upper five address bits come from the volatile image; the whole address is used to match serial-bus requests.
// - In soft mode address bits 2:1 follow strap 1: low 0, mid 1, high 3.
// - In hard mode the two lowest address bits are forced to 00.
// - The upper five address bits change only through the volatile image, never by register write.
`timescale 1ns/1ps

module psc_pin_strap_capture #(
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        SYS_RST_I,
    // Strap pins, level per pin from the three-level receivers
    input  wire logic        PIN_MODE_SELECT_PIN_I,
    input  wire logic [5:0]  STRAP_HIGH_I,
    input  wire logic [3:1]  STRAP_MID_I,
    // Volatile image load of the upper address bits
    input  wire logic        IMAGE_ADDR_LOAD_I,
    input  wire logic [4:0]  IMAGE_ADDR_UPPER_I,
    // Register read port
    input  wire logic [7:0]  REG_ADDR_I,
    output logic      [7:0]  REG_RDATA_O,
    // Serial-bus target match
    input  wire logic [6:0]  BUS_ADDR_I,
    output logic             ADDR_MATCH_O,
    output logic             SAMPLED_PIN_MODE_O
);

    // Only the plain two-flop synchroniser is built, so refuse any other depth.
    if (SYNC_STAGES != 2) begin : g_bad_sync_stages
        $error("SYNC_STAGES must be 2");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [9:0] pins_meta_r;
    logic [9:0] pins_sync_r;
    logic [9:0] pins_raw;
    logic       rst_seen_r;

    assign pins_raw = {PIN_MODE_SELECT_PIN_I, STRAP_MID_I, STRAP_HIGH_I};

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pins_meta_r <= 10'h000;
            pins_sync_r <= 10'h000;
        end else begin
            pins_meta_r <= pins_raw;
            pins_sync_r <= pins_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Strap decode
    // ------------------------------------------------------------------
    // The synchroniser still shows its reset zeros for two edges after release,
    // so the capture fires on the third; the board keeps straps stable meanwhile.
    logic [1:0] cap_wait_r;
    logic       cap_now;
    logic       mode_pin;
    logic [5:0] hard_strap_code;
    logic [1:0] lvl3;
    logic [1:0] lvl2;
    logic [1:0] lvl1;
    logic [2:0] soft_strap_code;
    logic [1:0] addr_low_code;

    assign mode_pin        = pins_sync_r[9];
    assign hard_strap_code = pins_sync_r[5:0];
    assign cap_now         = (cap_wait_r == psc_pkg::CAPTURE_WAIT_FIRE);

    assign lvl3 = pins_sync_r[3] ? psc_pkg::PSC_LVL_HIGH :
                  (pins_sync_r[8] ? psc_pkg::PSC_LVL_MID : psc_pkg::PSC_LVL_LOW);
    assign lvl2 = pins_sync_r[2] ? psc_pkg::PSC_LVL_HIGH :
                  (pins_sync_r[7] ? psc_pkg::PSC_LVL_MID : psc_pkg::PSC_LVL_LOW);
    assign lvl1 = pins_sync_r[1] ? psc_pkg::PSC_LVL_HIGH :
                  (pins_sync_r[6] ? psc_pkg::PSC_LVL_MID : psc_pkg::PSC_LVL_LOW);

    // Strap 3 picks the upper half of the code table, strap 2 the offset.
    assign soft_strap_code = ((lvl3 == psc_pkg::PSC_LVL_HIGH) ?
                              psc_pkg::SOFT_CODE_HIGH_BASE : 3'h0) + {1'b0, lvl2};

    assign addr_low_code = (lvl1 == psc_pkg::PSC_LVL_HIGH) ? psc_pkg::ADDR_LOW_FOR_HIGH :
                           (lvl1 == psc_pkg::PSC_LVL_MID)  ? psc_pkg::ADDR_LOW_FOR_MID :
                           psc_pkg::ADDR_LOW_FOR_LOW;

    // ------------------------------------------------------------------
    // Capture registers
    // ------------------------------------------------------------------
    logic [7:0] soft_cap_r;
    logic [7:0] hard_cap_r;
    logic [4:0] addr_upper_r;
    logic [1:0] addr_low_r;
    logic [7:0] soft_nxt;
    logic [7:0] hard_nxt;

    assign soft_nxt = {mode_pin, (mode_pin ? 3'h0 : soft_strap_code), 4'h0};
    assign hard_nxt = mode_pin ? {hard_strap_code, 2'h0} : 8'h00;

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cap_wait_r <= psc_pkg::CAPTURE_WAIT_RESET;
        end else if (cap_wait_r != 2'h0) begin
            cap_wait_r <= cap_wait_r - 2'h1;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            soft_cap_r <= psc_pkg::SOFT_CAPTURE_RESET;
            hard_cap_r <= psc_pkg::HARD_CAPTURE_RESET;
            addr_low_r <= psc_pkg::TARGET_ADDRESS_RESET[2:1];
        end else if (cap_now) begin
            soft_cap_r <= soft_nxt;
            hard_cap_r <= hard_nxt;
            addr_low_r <= mode_pin ? psc_pkg::ADDR_LOW_HARD : addr_low_code;
        end
    end

    // The register port is read-only, so only the image load can alter these.
    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            addr_upper_r <= psc_pkg::TARGET_ADDRESS_RESET[7:3];
        end else if (IMAGE_ADDR_LOAD_I) begin
            addr_upper_r <= IMAGE_ADDR_UPPER_I;
        end
    end

    // ------------------------------------------------------------------
    // Read mux and address match
    // ------------------------------------------------------------------
    logic [6:0] target_address_field;
    logic [7:0] rdata_nxt;

    assign target_address_field = {addr_upper_r, addr_low_r};
    assign rdata_nxt =
        (REG_ADDR_I == psc_pkg::REG_SOFT_CAPTURE)   ? soft_cap_r :
        (REG_ADDR_I == psc_pkg::REG_HARD_CAPTURE)   ? hard_cap_r :
        (REG_ADDR_I == psc_pkg::REG_TARGET_ADDRESS) ? {target_address_field, 1'b0} :
        8'h00;

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            REG_RDATA_O        <= 8'h00;
            ADDR_MATCH_O       <= 1'b0;
            SAMPLED_PIN_MODE_O <= 1'b0;
        end else begin
            REG_RDATA_O        <= rdata_nxt;
            ADDR_MATCH_O       <= (BUS_ADDR_I == target_address_field);
            SAMPLED_PIN_MODE_O <= soft_cap_r[psc_pkg::SOFT_MODE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_capture_hold: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        !cap_now |=> $stable(soft_cap_r) && $stable(hard_cap_r))
        else $error("Capture changed outside release.");
    a_mode_bit: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        cap_now |=> soft_cap_r[7] == $past(mode_pin))
        else $error("Mode bit not captured.");
    a_soft_code: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        cap_now && !mode_pin |=> soft_cap_r[6:4] <= 3'h5)
        else $error("Soft code out of range.");
    a_soft_zero: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        soft_cap_r[7] |-> soft_cap_r[6:4] == 3'h0)
        else $error("Soft field not zero in hard mode.");
    a_hard_code: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        cap_now && mode_pin |=> hard_cap_r[7:2] == $past(hard_strap_code))
        else $error("Hard code mismatch.");
    a_hard_zero: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        !soft_cap_r[7] |-> hard_cap_r == 8'h00)
        else $error("Hard field not zero in soft mode.");
    a_addr_read: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        REG_ADDR_I == psc_pkg::REG_TARGET_ADDRESS |=> REG_RDATA_O[0] == 1'b0)
        else $error("Reserved address bit set.");
    a_addr_hard: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        cap_now && mode_pin |=> addr_low_r == 2'h0)
        else $error("Hard mode address low bits not zero.");
    a_addr_mid: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        cap_now && !mode_pin && !pins_sync_r[1] && pins_sync_r[6] |=> addr_low_r == 2'h1)
        else $error("Mid strap address bits wrong.");
    a_addr_high: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        cap_now && !mode_pin && pins_sync_r[1] |=> addr_low_r == psc_pkg::ADDR_LOW_FOR_HIGH)
        else $error("High strap address bits wrong.");
    a_upper_hold: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        !IMAGE_ADDR_LOAD_I |=> $stable(addr_upper_r))
        else $error("Upper address bits changed without an image load.");
    a_addr_match: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        1'b1 |=> ADDR_MATCH_O == $past(BUS_ADDR_I == target_address_field))
        else $error("Address match does not follow the target address.");
    a_mode_output: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        1'b1 |=> SAMPLED_PIN_MODE_O == $past(soft_cap_r[psc_pkg::SOFT_MODE_BIT]))
        else $error("Mode output does not follow the captured mode bit.");

    // ------------------------------------------------------------------
    // Capture sequence checks
    // ------------------------------------------------------------------
    // Capture takes two steps: the counted wait expires, then the fields load.
    sequence s_capture_fire;
        cap_now;
    endsequence
    sequence s_fields_loaded;
        (soft_cap_r == $past(soft_nxt)) && (hard_cap_r == $past(hard_nxt));
    endsequence
    a_capture_load: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        s_capture_fire |=> s_fields_loaded)
        else $error("Capture did not load the decoded pins.");
    a_capture_park: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (cap_wait_r == '0) |=> (cap_wait_r == '0))
        else $error("Capture counter left its parked state.");

endmodule : psc_pin_strap_capture

// [verif/psc_board_straps.sv]
`timescale 1ns/1ps
module psc_board_straps (
    // Requested board setting, levels packed strap3, strap2, strap1
    input  wire logic       hard_mode_i,
    input  wire logic [5:0] hard_val_i,
    input  wire logic [5:0] soft_lvl_i,
    // Strap pins towards the device
    output logic            mode_o,
    output logic      [5:0] high_o,
    output logic      [3:1] mid_o
);
    // Straps are plain resistor levels, so they follow the setting at once.
    assign mode_o = hard_mode_i;
    always_comb begin
        high_o = hard_val_i;
        mid_o  = 3'h0;
        if (!hard_mode_i) begin
            high_o = 6'h00;
            for (int n = 1; n <= 3; n++) begin
                high_o[n] = soft_lvl_i[2*n-1 -: 2] == psc_pkg::PSC_LVL_HIGH;
                mid_o[n]  = soft_lvl_i[2*n-1 -: 2] == psc_pkg::PSC_LVL_MID;
            end
        end
    end
endmodule : psc_board_straps

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
    logic       clk_sys_i, sys_rst_i, hard_mode, image_load, mode_pin, addr_match, pin_mode;
    logic [5:0] hard_val, soft_lvl, strap_high;
    logic [4:0] image_upper;
    logic [7:0] reg_addr, reg_rdata;
    logic [6:0] bus_addr;
    logic [3:1] strap_mid;
    int         miscompares, n_compared;

    psc_board_straps psc_board_straps_inst (.hard_mode_i(hard_mode), .hard_val_i(hard_val),
        .soft_lvl_i(soft_lvl), .mode_o(mode_pin), .high_o(strap_high), .mid_o(strap_mid));
    psc_pin_strap_capture #(.SYNC_STAGES(2)) psc_pin_strap_capture_inst (
        .CLK_SYS_I(clk_sys_i), .SYS_RST_I(sys_rst_i), .PIN_MODE_SELECT_PIN_I(mode_pin),
        .STRAP_HIGH_I(strap_high), .STRAP_MID_I(strap_mid), .IMAGE_ADDR_LOAD_I(image_load),
        .IMAGE_ADDR_UPPER_I(image_upper), .REG_ADDR_I(reg_addr), .REG_RDATA_O(reg_rdata),
        .BUS_ADDR_I(bus_addr), .ADDR_MATCH_O(addr_match), .SAMPLED_PIN_MODE_O(pin_mode));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge clk_sys_i);
        reg_addr = addr;
        @(negedge clk_sys_i);
        check("register", reg_rdata, exp);
    endtask : expect_reg

    // The pins are disturbed after capture so every read also proves the hold.
    task automatic capture(input logic hm, input logic [5:0] hv, input logic [5:0] sl);
        @(negedge clk_sys_i);
        hard_mode = hm;
        hard_val  = hv;
        soft_lvl  = sl;
        sys_rst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        hard_mode = ~hm;
        hard_val  = ~hv;
        soft_lvl  = 6'h2A;
        repeat (2) @(negedge clk_sys_i);
    endtask : capture

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_soft;
        logic [1:0] l1;
        for (int i = 0; i < 6; i++) begin
            l1 = 2'((i + 1) % 3);
            capture(1'b0, 6'h3F, {(i >= 3) ? 2'h2 : 2'h0, 2'(i % 3), l1});
            expect_reg(psc_pkg::REG_SOFT_CAPTURE, {1'b0, 3'(i), 4'h0});
            expect_reg(psc_pkg::REG_HARD_CAPTURE, 8'h00);
            expect_reg(psc_pkg::REG_TARGET_ADDRESS, {5'h0A, (l1 == 2'h2) ? 2'h3 : l1, 1'b0});
            check("mode", {7'h00, pin_mode}, 8'h00);
        end
        $display("test soft done");
    endtask : test_soft

    task automatic test_hard;
        logic [5:0] v [3] = '{6'h00, 6'h3F, 6'h2A};
        for (int j = 0; j < 3; j++) begin
            capture(1'b1, v[j], 6'h2A);
            expect_reg(psc_pkg::REG_SOFT_CAPTURE, 8'h80);
            expect_reg(psc_pkg::REG_HARD_CAPTURE, {v[j], 2'h0});
            expect_reg(psc_pkg::REG_TARGET_ADDRESS, 8'h50);
            check("mode", {7'h00, pin_mode}, 8'h01);
        end
        $display("test hard done");
    endtask : test_hard

    task automatic test_image;
        capture(1'b0, 6'h00, 6'h01);
        expect_reg(8'h0B, 8'h00);
        @(negedge clk_sys_i);
        image_upper = 5'h13;
        image_load  = 1'b1;
        @(negedge clk_sys_i);
        image_load  = 1'b0;
        expect_reg(psc_pkg::REG_TARGET_ADDRESS, 8'h9A);
        bus_addr = 7'h4D;
        @(negedge clk_sys_i);
        check("match", {7'h00, addr_match}, 8'h01);
        bus_addr = 7'h4C;
        @(negedge clk_sys_i);
        check("match", {7'h00, addr_match}, 8'h00);
        $display("test image done");
    endtask : test_image

    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        repeat (5000) @(posedge clk_sys_i);
        miscompares++;
        stop_test();
    end

    initial begin
        {sys_rst_i, hard_mode, image_load} = 3'h4;
        {hard_val, soft_lvl, image_upper, reg_addr, bus_addr} = '0;
        miscompares = 0;
        n_compared  = 0;
        test_soft();
        test_hard();
        test_image();
        stop_test();
    end
endmodule : tb
